// File: hdl/wdt_pkg.sv
package wdt_pkg;
	localparam logic [7:0] WDT_OFF_COUNT = 8'h00;
	localparam logic [7:0] WDT_OFF_RELOAD = 8'h04;
	localparam logic [7:0] WDT_OFF_RESTART = 8'h08;
	localparam logic [7:0] WDT_OFF_CONTROL = 8'h0C;
	localparam logic [7:0] WDT_OFF_FLAG = 8'h10;
	localparam logic [7:0] WDT_OFF_FLAG_CLR = 8'h14;
	localparam logic [7:0] WDT_OFF_PULSE_LEN = 8'h18;
	localparam logic [7:0] WDT_OFF_VERSION = 8'h1C;
	localparam logic [7:0] WDT_OFF_IRQ_STAT = 8'h20;
	localparam logic [7:0] WDT_OFF_IRQ_MASK = 8'h24;
	localparam logic [31:0] WDT_RST_RELOAD = 32'h03EF_1480;
	localparam logic [15:0] WDT_RESTART_KEY = 16'h5AB9;
	localparam logic [4:0] WDT_RST_CONTROL = 5'h00;
	localparam logic [7:0] WDT_RST_PULSE_LEN = 8'hFF;
	localparam int WDT_BIT_ENABLE = 0;
	localparam int WDT_BIT_RST_EN = 1;
	localparam int WDT_BIT_INT_EN = 2;
	localparam int WDT_BIT_EXT_EN = 3;
	localparam int WDT_BIT_CLK_SEL = 4;
	typedef enum logic [1:0] {
		WDT_ST_RUN = 2'b00,
		WDT_ST_PULSE = 2'b01,
		WDT_ST_EXPIRED = 2'b10
	} wdt_state_t;
endpackage : wdt_pkg

// File: hdl/wdt_watchdog_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - 32-bit read-only down counter, decrements one per selected tick while enabled
// - reset sets live count and reload value to 0x3EF1480
// - writing 0x5AB9 to restart copies reload value into count and resumes; before the last pulse cycle it only loads count
// - restart register write-only, 16 bits, self-clears; other values do nothing
// - reload value loaded at reset and on every restart; freely read/write
// - control bit 0 enables counting; when clear the count holds
// - control bit 4 picks peripheral clock (0) or external clock (1)
// - at zero pulse reset, interrupt, external outputs per control bits 1,2,3
// - sticky read-only expiry flag set at zero, cleared by software only
// - any write to flag clear register clears the expiry flag, except in the cycle where an expiry sets it
// - pulse length register: outputs last value plus one cycles, default 0xFF
module wdt_watchdog_unit
	import wdt_pkg::*;
#(
	parameter logic [31:0] VERSION_VALUE = 32'h0001_0000 // arbitrary value
)(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic external_count_clock,
	output logic system_reset_pulse,
	output logic system_interrupt_pulse,
	output logic external_signal_pulse,
	output logic irq
);
	logic [31:0] count_ff, nxt_count;
	logic [31:0] reload_ff;
	logic [4:0] control_ff;
	logic flag_ff, nxt_flag;
	logic [7:0] pulse_len_ff;
	logic [7:0] pulse_cnt_ff, nxt_pulse_cnt;
	logic [2:0] pulse_out_ff, nxt_pulse_out;
	wdt_state_t state_ff, nxt_state;
	logic [1:0] irq_stat_ff, nxt_irq_stat;
	logic [1:0] irq_mask_ff;
	logic [31:0] rdata_ff, nxt_rdata;
	logic ext_meta_ff, ext_sync_ff, ext_prev_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	wire wr_reload = reg_write && hit(reg_addr, WDT_OFF_RELOAD);
	wire wr_control = reg_write && hit(reg_addr, WDT_OFF_CONTROL);
	wire wr_pulse_len = reg_write && hit(reg_addr, WDT_OFF_PULSE_LEN);
	wire wr_irq_mask = reg_write && hit(reg_addr, WDT_OFF_IRQ_MASK);
	wire wr_flag_clr = reg_write && hit(reg_addr, WDT_OFF_FLAG_CLR);
	// only the magic key restarts; the register itself keeps no value
	wire restart = reg_write && hit(reg_addr, WDT_OFF_RESTART)
		&& (reg_wdata[15:0] == WDT_RESTART_KEY);
	wire rd_irq_stat = reg_read && hit(reg_addr, WDT_OFF_IRQ_STAT);

	// external clock edge detect after two-stage sync
	wire ext_tick = ext_sync_ff && !ext_prev_ff;
	wire tick = control_ff[WDT_BIT_CLK_SEL] ? ext_tick : 1'b1;
	wire counting = control_ff[WDT_BIT_ENABLE] && (state_ff == WDT_ST_RUN);
	wire reach_zero = counting && tick && (count_ff == 32'h0000_0001);
	wire zero_now = counting && (count_ff == 32'h0000_0000);
	wire expire = reach_zero || zero_now;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ext_meta_ff <= 1'b0;
			ext_sync_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
		end
		else
		begin
			ext_meta_ff <= external_count_clock;
			ext_sync_ff <= ext_meta_ff;
			ext_prev_ff <= ext_sync_ff;
		end
	end

	always_comb
	begin
		nxt_count = count_ff;
		if (restart)
			nxt_count = reload_ff;
		else if (counting && tick && count_ff != 32'h0000_0000)
			nxt_count = count_ff - 32'h0000_0001;
	end

	always_comb
	begin
		nxt_state = state_ff;
		nxt_pulse_cnt = pulse_cnt_ff;
		nxt_pulse_out = pulse_out_ff;
		case (state_ff)
			WDT_ST_RUN:
			begin
				if (expire && !restart)
				begin
					nxt_state = WDT_ST_PULSE;
					nxt_pulse_cnt = pulse_len_ff;
					nxt_pulse_out = {control_ff[WDT_BIT_EXT_EN],
						control_ff[WDT_BIT_INT_EN], control_ff[WDT_BIT_RST_EN]};
				end
			end
			WDT_ST_PULSE:
			begin
				if (pulse_cnt_ff == 8'h00)
				begin
					nxt_state = restart ? WDT_ST_RUN : WDT_ST_EXPIRED;
					nxt_pulse_out = 3'b000;
				end
				else
					nxt_pulse_cnt = pulse_cnt_ff - 8'h01;
			end
			WDT_ST_EXPIRED:
			begin
				if (restart)
					nxt_state = WDT_ST_RUN;
			end
			default:
			begin
				nxt_state = WDT_ST_RUN;
				nxt_pulse_out = 3'b000;
			end
		endcase
	end

	// set wins over clear
	wire enter_pulse = (state_ff == WDT_ST_RUN) && (nxt_state == WDT_ST_PULSE);
	assign nxt_flag = enter_pulse ? 1'b1 : (wr_flag_clr ? 1'b0 : flag_ff);
	// bit1 marks an expiry that lands while the previous one is still unacknowledged
	assign nxt_irq_stat = {enter_pulse && flag_ff, enter_pulse}
		| (rd_irq_stat ? 2'b00 : irq_stat_ff);

	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (reg_read)
		begin
			case (reg_addr)
				WDT_OFF_COUNT: nxt_rdata = count_ff;
				WDT_OFF_RELOAD: nxt_rdata = reload_ff;
				WDT_OFF_CONTROL: nxt_rdata = {27'h000_0000, control_ff};
				WDT_OFF_FLAG: nxt_rdata = {31'h0000_0000, flag_ff};
				WDT_OFF_PULSE_LEN: nxt_rdata = {24'h00_0000, pulse_len_ff};
				WDT_OFF_VERSION: nxt_rdata = VERSION_VALUE;
				WDT_OFF_IRQ_STAT: nxt_rdata = {30'h0000_0000, irq_stat_ff};
				WDT_OFF_IRQ_MASK: nxt_rdata = {30'h0000_0000, irq_mask_ff};
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_ff <= WDT_RST_RELOAD;
			reload_ff <= WDT_RST_RELOAD;
			control_ff <= WDT_RST_CONTROL;
			flag_ff <= 1'b0;
			pulse_len_ff <= WDT_RST_PULSE_LEN;
			pulse_cnt_ff <= 8'h00;
			pulse_out_ff <= 3'b000;
			state_ff <= WDT_ST_RUN;
			irq_stat_ff <= 2'b00;
			irq_mask_ff <= 2'b00;
			rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			count_ff <= nxt_count;
			if (wr_reload)
				reload_ff <= reg_wdata;
			if (wr_control)
				control_ff <= reg_wdata[4:0];
			flag_ff <= nxt_flag;
			if (wr_pulse_len)
				pulse_len_ff <= reg_wdata[7:0];
			pulse_cnt_ff <= nxt_pulse_cnt;
			pulse_out_ff <= nxt_pulse_out;
			state_ff <= nxt_state;
			irq_stat_ff <= nxt_irq_stat;
			if (wr_irq_mask)
				irq_mask_ff <= reg_wdata[1:0];
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign system_reset_pulse = pulse_out_ff[0];
	assign system_interrupt_pulse = pulse_out_ff[1];
	assign external_signal_pulse = pulse_out_ff[2];
	assign irq = |(irq_stat_ff & irq_mask_ff);

	sequence s_expire_seen;
		enter_pulse && control_ff[WDT_BIT_RST_EN];
	endsequence

	a_reset_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
		s_expire_seen |=> system_reset_pulse)
		else $error("reset pulse did not start after expiry");
	a_pulse_len_ff: assert property (@(posedge clk) disable iff (!resetn)
		(enter_pulse && control_ff[WDT_BIT_INT_EN] && pulse_len_ff == 8'h03)
		|=> system_interrupt_pulse [*4] ##1 !system_interrupt_pulse)
		else $error("interrupt pulse length wrong");
	a_restart_load: assert property (@(posedge clk) disable iff (!resetn)
		restart |=> count_ff == $past(reload_ff))
		else $error("restart did not reload count");
	a_bad_key_ignored: assert property (@(posedge clk) disable iff (!resetn)
		(reg_write && hit(reg_addr, WDT_OFF_RESTART) && !restart && !counting)
		|=> $stable(count_ff))
		else $error("non-key write changed the count");
	a_hold_disabled: assert property (@(posedge clk) disable iff (!resetn)
		(!control_ff[WDT_BIT_ENABLE] && !restart) |=> $stable(count_ff))
		else $error("count moved while disabled");
	a_count_dec: assert property (@(posedge clk) disable iff (!resetn)
		(counting && tick && !restart && count_ff != 32'h0000_0000)
		|=> count_ff == $past(count_ff) - 32'h0000_0001)
		else $error("count did not decrement by one");
	a_flag_set_wins: assert property (@(posedge clk) disable iff (!resetn)
		enter_pulse |=> flag_ff)
		else $error("expiry flag not set");
	a_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
		(wr_flag_clr && !enter_pulse) |=> !flag_ff)
		else $error("flag clear write ignored");
	a_ext_hold: assert property (@(posedge clk) disable iff (!resetn)
		(control_ff[WDT_BIT_CLK_SEL] && !ext_tick && !restart) |=> $stable(count_ff))
		else $error("count moved without external edge");
	a_once_only: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == WDT_ST_EXPIRED && !restart) |=> state_ff == WDT_ST_EXPIRED)
		else $error("expired state left without restart");

	// steps of one expiry, used by the properties below
	sequence s_run_expire;
		(state_ff == WDT_ST_RUN) && expire && !restart;
	endsequence

	sequence s_pulse_end;
		(state_ff == WDT_ST_PULSE) && (pulse_cnt_ff == 8'h00);
	endsequence

	sequence s_int_armed;
		enter_pulse && control_ff[WDT_BIT_INT_EN];
	endsequence

	sequence s_ext_armed;
		enter_pulse && control_ff[WDT_BIT_EXT_EN];
	endsequence

	sequence s_pulse_busy;
		(state_ff == WDT_ST_PULSE) && (pulse_cnt_ff != 8'h00);
	endsequence

	// helper: measured width of the reset pulse and the length armed for it
	logic [8:0] rst_width_ff;
	logic [7:0] len_seen_ff;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_width_ff <= 9'h000;
			len_seen_ff <= 8'h00;
		end
		else
		begin
			if (system_reset_pulse)
				rst_width_ff <= rst_width_ff + 9'h001;
			else
				rst_width_ff <= 9'h000;
			if (enter_pulse)
				len_seen_ff <= pulse_len_ff;
		end
	end

	a_run_to_pulse: assert property (@(posedge clk) disable iff (!resetn)
		s_run_expire |=> state_ff == WDT_ST_PULSE)
		else $error("expiry did not start the pulse phase");

	a_int_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
		s_int_armed |=> system_interrupt_pulse)
		else $error("interrupt pulse did not start after expiry");

	a_ext_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
		s_ext_armed |=> external_signal_pulse)
		else $error("external pulse did not start after expiry");

	a_rst_pulse_masked: assert property (@(posedge clk) disable iff (!resetn)
		(enter_pulse && !control_ff[WDT_BIT_RST_EN]) |=> !system_reset_pulse)
		else $error("reset pulse raised while disabled");

	a_pulse_end_quiet: assert property (@(posedge clk) disable iff (!resetn)
		s_pulse_end |=> pulse_out_ff == 3'b000)
		else $error("outputs still high after pulse end");

	a_pulse_to_expired: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == WDT_ST_PULSE && pulse_cnt_ff == 8'h00 && !restart)
		|=> state_ff == WDT_ST_EXPIRED)
		else $error("pulse end did not settle in expired state");

	a_pulse_cnt_load: assert property (@(posedge clk) disable iff (!resetn)
		enter_pulse |=> pulse_cnt_ff == $past(pulse_len_ff))
		else $error("pulse counter not loaded from length");

	a_pulse_cnt_step: assert property (@(posedge clk) disable iff (!resetn)
		s_pulse_busy |=> pulse_cnt_ff == $past(pulse_cnt_ff) - 8'h01)
		else $error("pulse counter did not step down");

	a_pulse_out_hold: assert property (@(posedge clk) disable iff (!resetn)
		s_pulse_busy |=> $stable(pulse_out_ff))
		else $error("outputs changed inside the pulse");

	a_rst_width: assert property (@(posedge clk) disable iff (!resetn)
		$fell(system_reset_pulse) |-> rst_width_ff == ({1'b0, len_seen_ff} + 9'h001))
		else $error("reset pulse width is not length plus one");

	a_zero_hold: assert property (@(posedge clk) disable iff (!resetn)
		(count_ff == 32'h0000_0000 && !restart) |=> count_ff == 32'h0000_0000)
		else $error("count left zero without restart");

	a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
		(flag_ff && !wr_flag_clr) |=> flag_ff)
		else $error("expiry flag dropped without clear");

	a_flag_on_expiry: assert property (@(posedge clk) disable iff (!resetn)
		(!flag_ff && !enter_pulse) |=> !flag_ff)
		else $error("expiry flag set without expiry");

	a_restart_no_pulse: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == WDT_ST_RUN && restart) |=> state_ff == WDT_ST_RUN)
		else $error("restart did not suppress expiry");

	a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
		!reg_read |=> reg_rdata == 32'h0000_0000)
		else $error("read data shown without a read");

	a_count_read: assert property (@(posedge clk) disable iff (!resetn)
		(reg_read && reg_addr == WDT_OFF_COUNT) |=> reg_rdata == $past(count_ff))
		else $error("count read returned wrong value");

	a_stat_set: assert property (@(posedge clk) disable iff (!resetn)
		enter_pulse |=> irq_stat_ff[0])
		else $error("expiry event not recorded in status");

	a_ext_one_tick: assert property (@(posedge clk) disable iff (!resetn)
		ext_tick |=> !ext_tick)
		else $error("one external edge counted twice");

	a_pclk_dec: assert property (@(posedge clk) disable iff (!resetn)
		(counting && !control_ff[WDT_BIT_CLK_SEL] && !restart && count_ff != 32'h0000_0000)
		|=> count_ff == $past(count_ff) - 32'h0000_0001)
		else $error("count missed a peripheral clock tick");
endmodule : wdt_watchdog_unit

// File: verification/wdt_sys_ctrl_model.sv
`timescale 1ns/100ps
// system reset/interrupt side: counts pulse cycles and reset pulse starts
module wdt_sys_ctrl_model
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic rst_p,
	input wire logic int_p,
	input wire logic ext_p,
	output int hi_rst,
	output int hi_int,
	output int hi_ext,
	output int n_rise
);
	logic rst_d;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hi_rst <= 0;
			hi_int <= 0;
			hi_ext <= 0;
			n_rise <= 0;
			rst_d <= 1'b0;
		end
		else
		begin
			rst_d <= rst_p;
			hi_rst <= hi_rst + int'(rst_p);
			hi_int <= hi_int + int'(int_p);
			hi_ext <= hi_ext + int'(ext_p);
			n_rise <= n_rise + int'(rst_p && !rst_d);
		end
	end
endmodule : wdt_sys_ctrl_model

// File: verification/wdt_watchdog_unit_tb_top.sv
`timescale 1ns/100ps
module wdt_watchdog_unit_tb_top;
	import wdt_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic ext_clk = 1'b0;
	logic rst_p;
	logic int_p;
	logic ext_p;
	logic irq;
	logic [31:0] d;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int hi_rst;
	int hi_int;
	int hi_ext;
	int n_rise;
	always #4 clk = ~clk;
	wdt_watchdog_unit uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .external_count_clock(ext_clk), .system_reset_pulse(rst_p),
		.system_interrupt_pulse(int_p), .external_signal_pulse(ext_p), .irq(irq));
	wdt_sys_ctrl_model ctl (.clk(clk), .resetn(resetn), .rst_p(rst_p), .int_p(int_p),
		.ext_p(ext_p), .hi_rst(hi_rst), .hi_int(hi_int), .hi_ext(hi_ext), .n_rise(n_rise));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk) reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk) reg_write <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk) reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk) reg_read <= 1'b0;
		#1 d = reg_rdata;
		chk(d, exp);
	endtask : rdchk
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			err_total++;
			test_done();
		end
	end
	task automatic t_reset();
		rdchk(WDT_OFF_COUNT, WDT_RST_RELOAD);
		rdchk(WDT_OFF_RELOAD, WDT_RST_RELOAD);
		rdchk(WDT_OFF_CONTROL, 32'(WDT_RST_CONTROL));
		rdchk(WDT_OFF_PULSE_LEN, 32'(WDT_RST_PULSE_LEN));
		rdchk(WDT_OFF_FLAG, 32'h0000_0000);
		rdchk(8'h40, 32'h0000_0000);
		wr(WDT_OFF_COUNT, 32'h0000_1234);
		rdchk(WDT_OFF_COUNT, WDT_RST_RELOAD);
		$display("reset test done");
	endtask : t_reset
	task automatic t_restart();
		wr(WDT_OFF_RELOAD, 32'h0000_0005);
		rdchk(WDT_OFF_RELOAD, 32'h0000_0005);
		wr(WDT_OFF_RESTART, 32'h0000_5AB8);
		rdchk(WDT_OFF_COUNT, WDT_RST_RELOAD);
		wr(WDT_OFF_RESTART, 32'(WDT_RESTART_KEY));
		repeat (5) @(posedge clk);
		rdchk(WDT_OFF_COUNT, 32'h0000_0005);
		$display("restart test done");
	endtask : t_restart
	task automatic t_expiry();
		wr(WDT_OFF_PULSE_LEN, 32'h0000_0003);
		wr(WDT_OFF_IRQ_MASK, 32'h0000_0001);
		wr(WDT_OFF_CONTROL, 32'h0000_000F);
		repeat (40) @(posedge clk);
		#1 chk(hi_rst, 32'h0000_0004);
		chk(hi_int, 32'h0000_0004);
		chk(hi_ext, 32'h0000_0004);
		chk(n_rise, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		rdchk(WDT_OFF_COUNT, 32'h0000_0000);
		rdchk(WDT_OFF_FLAG, 32'h0000_0001);
		rdchk(WDT_OFF_FLAG, 32'h0000_0001);
		@(posedge clk) reg_addr <= WDT_OFF_IRQ_STAT;
		reg_read <= 1'b1;
		@(posedge clk) reg_read <= 1'b0;
		#1 chk(32'(reg_rdata[1:0]), 32'h0000_0001);
		@(posedge clk);
		#1 chk(32'(irq), 32'h0000_0000);
		wr(WDT_OFF_FLAG_CLR, 32'h0000_0000);
		rdchk(WDT_OFF_FLAG, 32'h0000_0000);
		$display("expiry test done");
	endtask : t_expiry
	task automatic t_external_count_clock();
		wr(WDT_OFF_RELOAD, 32'h0000_0064);
		wr(WDT_OFF_CONTROL, 32'h0000_0011);
		wr(WDT_OFF_RESTART, 32'(WDT_RESTART_KEY));
		repeat (10) @(posedge clk);
		rdchk(WDT_OFF_COUNT, 32'h0000_0064);
		repeat (2)
		begin
			repeat (4) @(posedge clk);
			ext_clk <= 1'b1;
			repeat (4) @(posedge clk);
			ext_clk <= 1'b0;
		end
		repeat (6) @(posedge clk);
		rdchk(WDT_OFF_COUNT, 32'h0000_0062);
		$display("external clock test done");
	endtask : t_external_count_clock
	initial
	begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_restart();
		t_expiry();
		t_external_count_clock();
		test_done();
	end
endmodule : wdt_watchdog_unit_tb_top
